// ---- hw/pst_pkg.sv ----
// Purpose: Shared constants and types for the protection stage pickup timer.
// Assumes: One 200 MHz clock; the program cycle is also the delay step.
// Notes:   The inverse curve weights are coarse stand-ins, not real curves.
//
// Overview of operation
// - Compare magnitude with pickup level on every evaluation cycle.
// - Once picked up, drop out only below 97 % of pickup level.
// - Sample the block input at the start of each cycle, hold it.
// - Pickup with block inactive raises start and begins trip timing.
// - Pickup with block active raises blocked, no start, no timing.
// - Block during start drops start and runs the release timing.
// - Each blocking gives a display event and a stamped event record.
// - In test mode a software switch drives the block input.
// - Release behaviour is configurable when pickup drops before trip.
// - Instant operation trips in the same cycle as start.
// - Definite time trips after the set delay of continuous pickup.
// - Inverse time delay follows pickup level versus magnitude.
// - In inverse mode the definite delay is a floor; zero removes it.
// - Delay type: 0 definite, 1 inverse; resets to definite.
// - Definite delay in 5 ms steps, default 40 ms.
// - Definite delay zero trips instantly; nonzero is delayed.
// - Curve series: 0 IEC, 1 IEEE; default IEC; inverse mode only.
// - IEC curve select 0..4 normal, extreme, very, long, param.
// - Time multiplier in 0.01 s steps, default 0.05 s, inverse only.
package pst_pkg;

  // Clock rate and program cycle; the cycle equals the 5 ms delay step.
  localparam int CLK_MHZ   = 200;
  localparam int TICK_US   = 5000;
  localparam int TICK_CYC  = TICK_US * CLK_MHZ;
  localparam int BLK_LEAD_US = 5000;

  // Field widths.
  localparam int MAG_W = 16;
  localparam int DLY_W = 19;
  localparam int MUL_W = 12;
  localparam int REL_W = 8;
  localparam int FLT_W = 3;
  localparam int ACC_W = 40;
  localparam int THR_W = 32;

  // Built-in reset ratio of 97 %.
  localparam int RST_NUM = 97;
  localparam int RST_DEN = 100;

  // Selector encodings.
  localparam logic DLY_DEFINITE = 1'h0;
  localparam logic DLY_INVERSE  = 1'h1;
  localparam logic SER_IEC      = 1'h0;
  localparam logic SER_IEEE     = 1'h1;
  localparam logic [2:0] IEC_NI    = 3'h0;
  localparam logic [2:0] IEC_EI    = 3'h1;
  localparam logic [2:0] IEC_VI    = 3'h2;
  localparam logic [2:0] IEC_LTI   = 3'h3;
  localparam logic [2:0] IEC_PARAM = 3'h4;

  // Reset values: 40 ms is 8 steps, 0.05 s is 5 multiplier steps.
  localparam logic [DLY_W-1:0] DEF_DLY_RST = 19'h00008;
  localparam logic [MUL_W-1:0] MUL_RST     = 12'h005;

  // Stage settings, loaded together.
  typedef struct packed {
    logic             delay_type;
    logic             curve_series;
    logic [2:0]       curve_sel;
    logic [DLY_W-1:0] def_delay;
    logic [MUL_W-1:0] time_mult;
    logic             rel_hold;
    logic [REL_W-1:0] rel_time;
  } pst_cfg_t;

  localparam pst_cfg_t CFG_RST = '{DLY_DEFINITE, SER_IEC, IEC_NI,
    DEF_DLY_RST, MUL_RST, 1'h0, 8'h00};

  // Record captured at a blocking occurrence.
  typedef struct packed {
    logic [MAG_W-1:0] mag;
    logic [FLT_W-1:0] fault;
  } pst_evt_t;

  // Coarse curve steepness weight per series and characteristic.
  function automatic logic [3:0] pst_coef(input logic ser,
                                          input logic [2:0] sel);
    case ({ser, sel})
      4'h0:    pst_coef = 4'h2;
      4'h1:    pst_coef = 4'h8;
      4'h2:    pst_coef = 4'h4;
      4'h3:    pst_coef = 4'hF;
      4'h8:    pst_coef = 4'h1;
      4'h9:    pst_coef = 4'h3;
      4'hA:    pst_coef = 4'h6;
      4'hB:    pst_coef = 4'hC;
      default: pst_coef = 4'h1;
    endcase
  endfunction

endpackage

// ---- hw/pst_stage.sv ----
// Purpose: One protection stage: pickup with hysteresis, blocking, start,
//          instant, definite and inverse trip timing, release hold.
// Assumes: Magnitude, level and settings come from logic on this clock;
//          block, test mode and test switch come from outside and are
//          synchronised here.
// Notes:   Everything is decided on the program cycle tick only.
module pst_stage
  import pst_pkg::*;
#(
  parameter int TICK_CYCLES = pst_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // Measurement path.
  input  wire logic [pst_pkg::MAG_W-1:0] meas_mag,
  input  wire logic [pst_pkg::MAG_W-1:0] pickup_level,
  input  wire logic [pst_pkg::FLT_W-1:0] fault_type,
  // Settings, taken on cfg_load.
  input  wire logic                      cfg_load,
  input  wire pst_pkg::pst_cfg_t         cfg_in,
  // Blocking matrix and commissioning test.
  input  wire logic                      block_in,
  input  wire logic                      test_mode,
  input  wire logic                      test_block_sw,
  // Stage outputs.
  output logic                           pickup_out,
  output logic                           start_out,
  output logic                           trip_out,
  output logic                           blocked_out,
  output logic                           blk_event,
  output logic                           disp_event,
  output pst_pkg::pst_evt_t              blk_record,
  output pst_pkg::pst_cfg_t              cfg_out,
  output logic                           tick_out
);
  import pst_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES);

  typedef enum logic [1:0] {
    ST_IDLE, ST_START, ST_HOLD, ST_BLOCK
  } pst_st_t;

  logic [CW-1:0]     tick_cnt_r;
  logic              tick_r;
  logic [2:0]        syn1_r;
  logic [2:0]        syn2_r;
  logic              blk_r;
  logic              pick_r;
  logic              start_r;
  logic              trip_r;
  logic              blocked_r;
  logic              blk_evt_r;
  logic              disp_evt_r;
  pst_evt_t          rec_r;
  pst_cfg_t          cfg_r;
  pst_st_t           st_r;
  pst_st_t           st_nxt;
  logic [DLY_W-1:0]  el_r;
  logic [ACC_W-1:0]  acc_r;
  logic [REL_W-1:0]  rel_r;

  logic [MAG_W+6:0]  prod_w;
  logic [MAG_W-1:0]  drop_lvl;
  logic              blk_eff;
  logic              pick_nxt;
  logic              start_nxt;
  logic              blocked_nxt;
  logic [MAG_W-1:0]  diff;
  logic [THR_W-1:0]  thr;
  logic              floor_ok;
  logic              dt_hit;
  logic              inv_hit;
  logic              trip_nxt;

  // Program cycle divider; one pulse every TICK_CYCLES clocks.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == CW'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  // Two-stage synchronisers for the pins from outside this domain.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      syn1_r <= 3'h0;
      syn2_r <= 3'h0;
    end else begin
      syn1_r <= {test_block_sw, test_mode, block_in};
      syn2_r <= syn1_r;
    end
  end

  // Test mode hands the block input to the software switch.
  assign blk_eff = syn2_r[1] ? syn2_r[2] : syn2_r[0];

  // Settings register; the selectors come up in definite time mode.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_r <= CFG_RST;
    end else if (cfg_load) begin
      cfg_r <= cfg_in;
    end
  end

  // Drop-out level is 97 % of the pickup level, rounded down.
  assign prod_w   = {7'h00, pickup_level} * (MAG_W + 7)'(RST_NUM);
  assign drop_lvl = MAG_W'(prod_w / (MAG_W + 7)'(RST_DEN));

  // Pickup decision with hysteresis.
  always_comb begin
    if (pick_r) begin
      pick_nxt = (meas_mag >= drop_lvl);
    end else begin
      pick_nxt = (meas_mag >= pickup_level);
    end
  end

  // Start only while the cycle's sampled block is inactive.
  assign start_nxt   = pick_nxt & ~blk_r;
  assign blocked_nxt = pick_nxt & blk_r;

  // The block must settle by the previous tick to stop a trip due now.
  // Sampling happens on the tick, so the sampled value drives the
  // decisions of the following cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blk_r <= 1'b0;
    end else if (tick_r) begin
      blk_r <= blk_eff;
    end
  end

  // Excess over the level feeds the inverse time integrator.
  assign diff = (meas_mag > pickup_level) ?
                (meas_mag - pickup_level) : '0;

  // Integrator target grows with multiplier, level and curve weight,
  // so trip time is roughly mult * level * weight / (mag - level).
  // Each factor is widened first so the product is not cut to 16 bits.
  assign thr = THR_W'(cfg_r.time_mult) * THR_W'(pickup_level) *
               THR_W'(pst_coef(cfg_r.curve_series,
                               cfg_r.curve_sel));

  // A zero definite delay removes the floor and, in definite time mode, gives instant trip.
  assign floor_ok = (cfg_r.def_delay == '0) ||
                    (el_r >= cfg_r.def_delay);
  assign dt_hit   = floor_ok;
  assign inv_hit  = (acc_r >= ACC_W'(thr)) && floor_ok;

  // Series and curve only matter once inverse time is chosen.
  always_comb begin
    if (cfg_r.delay_type == DLY_INVERSE) begin
      trip_nxt = start_nxt & inv_hit;
    end else begin
      trip_nxt = start_nxt & dt_hit;
    end
  end

  // Stage state: idle, started, release hold, blocked.
  always_comb begin
    case (st_r)
      ST_IDLE, ST_HOLD, ST_START: begin
        if (start_nxt) begin
          st_nxt = ST_START;
        end else if (blocked_nxt && st_r != ST_START) begin
          st_nxt = ST_BLOCK;
        end else if (cfg_r.rel_hold && st_r != ST_IDLE &&
                     rel_r < cfg_r.rel_time) begin
          st_nxt = ST_HOLD;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_BLOCK: begin
        if (start_nxt) begin
          st_nxt = ST_START;
        end else if (blocked_nxt) begin
          st_nxt = ST_BLOCK;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // State and output flags advance on the tick only.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r      <= ST_IDLE;
      pick_r    <= 1'b0;
      start_r   <= 1'b0;
      trip_r    <= 1'b0;
      blocked_r <= 1'b0;
    end else if (tick_r) begin
      st_r      <= st_nxt;
      pick_r    <= pick_nxt;
      start_r   <= start_nxt;
      trip_r    <= trip_nxt;
      blocked_r <= blocked_nxt;
    end
  end

  // Trip timers. A held release keeps the elapsed time so a returning
  // pickup resumes; otherwise dropping out clears them at once.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      el_r  <= '0;
      acc_r <= '0;
      rel_r <= '0;
    end else if (tick_r) begin
      if (start_nxt) begin
        if (el_r != '1) begin
          el_r <= el_r + 1'b1;
        end
        acc_r <= acc_r + ACC_W'(diff);
        rel_r <= '0;
      end else if (st_nxt == ST_HOLD) begin
        rel_r <= rel_r + 1'b1;
      end else begin
        el_r  <= '0;
        acc_r <= '0;
        rel_r <= '0;
      end
    end
  end

  // Blocking occurrences: one-clock event pulses and a stamped record.
  // The record holds the magnitude and fault type at the blocking tick.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blk_evt_r  <= 1'b0;
      disp_evt_r <= 1'b0;
      rec_r      <= '0;
    end else if (tick_r && blocked_nxt && !blocked_r) begin
      blk_evt_r  <= 1'b1;
      disp_evt_r <= 1'b1;
      rec_r      <= '{meas_mag, fault_type};
    end else begin
      blk_evt_r  <= 1'b0;
      disp_evt_r <= 1'b0;
    end
  end

  // All outputs come straight from flip-flops.
  assign pickup_out  = pick_r;
  assign start_out   = start_r;
  assign trip_out    = trip_r;
  assign blocked_out = blocked_r;
  assign blk_event   = blk_evt_r;
  assign disp_event  = disp_evt_r;
  assign blk_record  = rec_r;
  assign cfg_out     = cfg_r;
  assign tick_out    = tick_r;

endmodule

// ---- verif/pst_meas_model.sv ----
// Purpose: Measurement path and blocking matrix facing the stage.
// Assumes: Bench requests arrive on the stage clock.
// Notes:   Values land one clock after the request, like a register.
module pst_meas_model
  import pst_pkg::*;
(
  // Clock.
  input  wire logic                      clock,
  // Requests from the bench.
  input  wire logic [pst_pkg::MAG_W-1:0] mag_req,
  input  wire logic                      blk_req,
  // Lines towards the stage.
  output logic [pst_pkg::MAG_W-1:0]      meas_mag = '0,
  output logic [pst_pkg::MAG_W-1:0]      pickup_level = '0,
  output logic [pst_pkg::FLT_W-1:0]      fault_type = '0,
  output logic                           block_in = 1'h0
);
  // Fixed level of 1000; the fault code value is arbitrary.
  always_ff @(posedge clock) begin
    meas_mag     <= mag_req;
    pickup_level <= 16'h03E8;
    fault_type   <= 3'h5;
    block_in     <= blk_req;
  end
endmodule

// ---- verif/pst_stage_properties.sv ----
// Purpose: Port-level timing properties of the protection stage.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Tick spacing is held in a counter, not a long repetition.
module pst_stage_properties
  import pst_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset.
  input wire logic                      clock,
  input wire logic                      sys_rst,
  // Watched inputs.
  input wire logic [pst_pkg::MAG_W-1:0] meas_mag,
  input wire logic                      cfg_load,
  input wire pst_pkg::pst_cfg_t         cfg_in,
  // Watched outputs.
  input wire logic                      pickup_out,
  input wire logic                      start_out,
  input wire logic                      trip_out,
  input wire logic                      blocked_out,
  input wire logic                      blk_event,
  input wire logic                      disp_event,
  input wire pst_pkg::pst_evt_t         blk_record,
  input wire pst_pkg::pst_cfg_t         cfg_out,
  input wire logic                      tick_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] gap_r;

  // Clocks since the last tick; a stalled tick would let it run away.
  always_ff @(posedge clock) begin
    if (sys_rst || tick_out) gap_r <= 32'h0;
    else gap_r <= gap_r + 32'h1;
  end

  sequence s_dt_start;
    $rose(start_out) && cfg_out.delay_type == DLY_DEFINITE;
  endsequence

  a_tick_gap: assert property (gap_r <= TICK_CYCLES)
    else $error("program tick missing");
  a_flag_tick: assert property ($changed({start_out, trip_out}) |-> $past(tick_out))
    else $error("flag moved off tick");
  a_no_both: assert property (!(start_out && blocked_out))
    else $error("start while blocked");
  a_trip_start: assert property (trip_out |-> start_out)
    else $error("trip without start");
  a_instant_trip: assert property (s_dt_start ##0 cfg_out.def_delay == '0 |-> trip_out)
    else $error("zero delay did not trip");
  a_dt_wait: assert property (s_dt_start ##0 cfg_out.def_delay != '0 |-> !trip_out)
    else $error("delayed stage tripped early");
  a_drop_clear: assert property ($fell(pickup_out) |-> !start_out && !trip_out)
    else $error("drop left start or trip");
  a_evt_pair: assert property (blk_event == disp_event)
    else $error("events not paired");
  a_evt_fresh: assert property (blk_event |-> blocked_out && !$past(blocked_out))
    else $error("event without new blocking");
  a_evt_record: assert property (blk_event |-> blk_record.mag == $past(meas_mag))
    else $error("record magnitude wrong");
  a_cfg_take: assert property (cfg_load |=> cfg_out == $past(cfg_in))
    else $error("settings not taken");
endmodule

// ---- verif/pst_stage_tb.sv ----
// Purpose: Self-checking bench for the protection stage.
// Assumes: Program tick shortened to four clocks.
// Notes:   Flags are sampled just after the edge that ends a tick.
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: %0h %0h", $time, a, e); end end
module pst_stage_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pst_pkg::*;
  localparam int TICK_CYCLES = 4;
  logic clock = 1'h0, sys_rst = 1'h1, cfg_load = 1'h0, blk_req = 1'h0;
  logic test_mode = 1'h0, test_block_sw = 1'h0;
  logic [MAG_W-1:0] mag_req = '0, meas_mag, pickup_level;
  logic [FLT_W-1:0] fault_type;
  logic block_in, pickup_out, start_out, trip_out, blocked_out;
  logic blk_event, disp_event, tick_out;
  pst_cfg_t cfg_in = CFG_RST, cfg_out, c;
  pst_evt_t blk_record;
  int n_mismatch = 0, compares = 0, n_evt = 0;

  always #2.5 clock = ~clock;
  // Counted on the falling edge, away from the edge that launches it.
  always @(negedge clock) if (blk_event === 1'b1) n_evt++;

  pst_meas_model i_pst_meas_model (.clock, .mag_req, .blk_req, .meas_mag,
    .pickup_level, .fault_type, .block_in);
  pst_stage #(.TICK_CYCLES(TICK_CYCLES)) i_pst_stage (.clock, .sys_rst,
    .meas_mag, .pickup_level, .fault_type, .cfg_load, .cfg_in, .block_in,
    .test_mode, .test_block_sw, .pickup_out, .start_out, .trip_out,
    .blocked_out, .blk_event, .disp_event, .blk_record, .cfg_out, .tick_out);

  task automatic print_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Waits n ticks; a tick that never comes ends the run.
  task automatic wait_ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (tick_out !== 1'b1 && k < 20) begin
        @(negedge clock);
        k++;
      end
      if (k == 20) begin
        n_mismatch++;
        print_verdict();
      end
      @(posedge clock);
      #1;
    end
  endtask

  task automatic step(input logic [MAG_W-1:0] m, input logic b, input int n);
    @(posedge clock);
    mag_req <= m;
    blk_req <= b;
    wait_ticks(n);
  endtask

  task automatic load(input pst_cfg_t v);
    @(posedge clock);
    cfg_in <= v;
    cfg_load <= 1'h1;
    @(posedge clock);
    cfg_load <= 1'h0;
    #1;
    `CHK(cfg_out, v)
    wait_ticks(1);
  endtask

  task automatic set_test(input logic v);
    @(posedge clock);
    test_mode <= v;
    test_block_sw <= v;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    #1;
    `CHK(cfg_out, CFG_RST)
    c = CFG_RST;
    c.def_delay = 19'h00002;
    load(c);
    // Definite delay of two ticks, then hysteresis at its exact floor.
    step(16'h044C, 1'h0, 1);
    `CHK({start_out, trip_out}, 2'h2)
    step(16'h044C, 1'h0, 1);
    `CHK(trip_out, 1'h0)
    step(16'h044C, 1'h0, 1);
    `CHK(trip_out, 1'h1)
    step(16'h03CA, 1'h0, 1);
    `CHK({pickup_out, start_out, trip_out}, 3'h7)
    step(16'h03C9, 1'h0, 1);
    `CHK({pickup_out, start_out, trip_out}, 3'h0)
    // Blocking while started, then blocking ahead of pickup.
    step(16'h044C, 1'h0, 1);
    step(16'h044C, 1'h1, 3);
    `CHK({start_out, trip_out}, 2'h0)
    step(16'h0000, 1'h0, 3);
    step(16'h0000, 1'h1, 3);
    n_evt = 0;
    step(16'h04B0, 1'h1, 1);
    `CHK({blocked_out, start_out}, 2'h2)
    `CHK(blk_record, {16'h04B0, 3'h5})
    step(16'h04B0, 1'h1, 2);
    `CHK(n_evt, 1)
    step(16'h0000, 1'h0, 3);
    set_test(1'h1);
    step(16'h04B0, 1'h0, 4);
    `CHK({blocked_out, start_out}, 2'h2)
    set_test(1'h0);
    step(16'h0000, 1'h0, 3);
    // Zero delay trips with start; inverse mode keeps the floor.
    c.def_delay = '0;
    load(c);
    step(16'h044C, 1'h0, 1);
    `CHK({start_out, trip_out}, 2'h3)
    step(16'h0000, 1'h0, 1);
    c.delay_type = DLY_INVERSE;
    c.def_delay = 19'h00006;
    c.time_mult = 12'h001;
    load(c);
    step(16'h07D0, 1'h0, 4);
    `CHK(trip_out, 1'h0)
    step(16'h07D0, 1'h0, 4);
    `CHK(trip_out, 1'h1)
    // Held release keeps elapsed time, so a return trips one tick early.
    step(16'h0000, 1'h0, 1);
    c.delay_type = DLY_DEFINITE;
    c.def_delay = 19'h00003;
    c.rel_hold = 1'h1;
    c.rel_time = 8'h02;
    load(c);
    step(16'h044C, 1'h0, 1);
    step(16'h0000, 1'h0, 1);
    `CHK({start_out, trip_out}, 2'h0)
    step(16'h044C, 1'h0, 2);
    `CHK(trip_out, 1'h0)
    step(16'h044C, 1'h0, 1);
    `CHK(trip_out, 1'h1)
    print_verdict();
  end
endmodule

bind pst_stage pst_stage_properties #(.TICK_CYCLES(TICK_CYCLES))
  i_pst_stage_properties (.clock, .sys_rst, .meas_mag, .cfg_load, .cfg_in,
  .pickup_out, .start_out, .trip_out, .blocked_out, .blk_event, .disp_event,
  .blk_record, .cfg_out, .tick_out);
